/* File: hdl/gbm_regmap.sv */
/*
 Register bank selection, general register pairs and peripheral register
 decode of a 4-bit CPU. Assumes the execution unit presents one request per
 cycle on the same clock and handles the stack memory itself.
*/
// How it works
// - four banks of eight nibbles at 00H-1FH
// - active bank is enable AND select
// - enable flag saved on call, restored on return
// - interrupt entry loads enable from vector
// - bit instructions write enable, select instruction selects
// - bank layout A X L H E D C B
// - pairs from active bank and bit0-flipped bank
// - XA accumulator, HL DE DL pointers
// - F80H-FFFH decode to peripheral registers
// - display memory 1E0H-1F7H in memory bank 1
// - direct access needs enable 0 or select 15
// - fmem bits reachable in any bank setting
// - HL indirect nibble and byte accesses reach peripherals with enable 1 and select 15
// - stack pointer 8-bit only, bit0 zero
// - bank selects read 4 or 8 bits
// - watchdog enable write-only, cannot clear
// - mode registers bit-manipulable only on bit3
// - interval timer count read-only, 8-bit
// - timer0 output enable write-only bit
// - timer2 control bit3 write-only
`include "gbm_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module gbm_regmap (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire gbm_pkg::gbm_req_t req_i,
	input wire gbm_pkg::gbm_ctl_t ctl_i,
	input wire logic [7:0] bt_count_i,
	input wire logic [7:0] t2_count_i,
	input wire logic [7:0] t0_count_i,
	output gbm_pkg::gbm_rsp_t rsp_o,
	output logic [1:0] active_reg_bank_o,
	output logic reg_bank_enable_o,
	output logic mem_bank_enable_o,
	output logic [3:0] mem_bank_select_o,
	output logic [7:0] acc_pair_o,
	output logic [7:0] main_pointer_pair_o,
	output logic [7:0] aux_pointer_pair_o,
	output logic [7:0] aux_pointer_pair_b_o,
	output logic [7:0] general_pair_b_o,
	output logic [7:0] acc_pair_alt_o,
	output logic [7:0] stack_pointer_o,
	output logic [3:0] stack_bank_selection_o,
	output logic watchdog_enable_flag_o,
	output logic timer0_output_enable_o,
	output logic [31:0] ctl_regs_o
);

////////////////////////////////////////////////////////////////////////////
// Storage
logic [3:0] gpr_r [0:31];
logic reg_bank_enable_r;
logic [1:0] reg_bank_select_r;
logic mem_bank_enable_r;
logic [3:0] mem_bank_select_r;
logic [7:0] rbe_stack_r;
logic [6:0] sp_hi_r;
logic [3:0] sbs_r;
logic [3:0] btm_r;
logic wdt_r;
logic [7:0] display_mode_r;
logic [3:0] display_control_r;
logic [3:0] lps_r;
logic [7:0] tm2_r;
logic [3:0] t2c_r;
logic [7:0] timer2_modulo_r;
logic [7:0] wm_r;
logic [7:0] tm0_r;
logic timer0_output_enable_r;
logic [7:0] timer0_modulo_r;
logic [7:0] tm1_r;
gbm_pkg::gbm_rsp_t rsp_r;

// Bit merge used by the general registers and the btm_r and t2c_r nibbles
function automatic logic [3:0] bit_merge(input logic [3:0] old, input logic [1:0] b,
		input logic v);
	logic [3:0] r;
	r = old;
	r[b] = v;
	return r;
endfunction

// Register index inside a bank
function automatic logic [4:0] gpr_idx(input logic [1:0] bank, input logic [2:0] off);
	return {bank, off};
endfunction

////////////////////////////////////////////////////////////////////////////
// Bank and address decode
wire [1:0] rb;
wire [1:0] rb_alt;
wire mb_io_ok;
wire fmem_hit;
wire is_bit;
wire is_nib;
wire is_byte;
wire [11:0] ea;
wire in_io;
wire io_ok;
wire gpr_hit;
wire disp_hit;
wire wr_io;
wire nib_sel;
wire [7:0] wdat;
wire bit_val;
assign rb = reg_bank_select_r & {2{reg_bank_enable_r}};
assign rb_alt = {rb[1], ~rb[0]};
assign is_bit = (req_i.width == gbm_pkg::GBM_BIT);
assign is_nib = (req_i.width == gbm_pkg::GBM_NIB);
assign is_byte = (req_i.width == gbm_pkg::GBM_BYTE);
assign mb_io_ok = ~mem_bank_enable_r | (mem_bank_select_r == `GBM_MBS_IO);
assign fmem_hit = is_bit && (((req_i.addr >= `GBM_FMEM_INT_FIRST) &&
	(req_i.addr <= `GBM_FMEM_INT_LAST)) || ((req_i.addr >= `GBM_FMEM_PORT_FIRST) &&
	(req_i.addr <= `GBM_FMEM_PORT_LAST)));
// Byte access drops address bit 0 so a pair is always even-aligned
assign ea = is_byte ? {req_i.addr[11:1], 1'b0} : req_i.addr;
assign in_io = req_i.valid && (ea >= `GBM_IO_FIRST);
// HL indirect needs explicit select 15
assign io_ok = in_io && ((req_i.mode == gbm_pkg::GBM_FMEM) ? fmem_hit :
	(req_i.mode == gbm_pkg::GBM_IND_HL) ? (mem_bank_enable_r &&
	mem_bank_select_r == `GBM_MBS_IO && !is_bit) :
	(req_i.mode == gbm_pkg::GBM_DIRECT) ? mb_io_ok : 1'b0);
assign gpr_hit = req_i.valid && (ea <= `GBM_GPR_LAST) &&
	((req_i.mode == gbm_pkg::GBM_IND_DE) || !mem_bank_enable_r ||
	(mem_bank_select_r == `GBM_MBS_GPR));
assign disp_hit = req_i.valid && (ea >= `GBM_DISP_FIRST) && (ea <= `GBM_DISP_LAST) &&
	mem_bank_enable_r && (mem_bank_select_r == `GBM_MBS_DISP);
assign wr_io = io_ok && req_i.wr;
assign nib_sel = is_nib && ea[0];
assign wdat = req_i.wdata;
assign bit_val = req_i.wdata[0];

////////////////////////////////////////////////////////////////////////////
// Peripheral read mux
logic [7:0] io_rd;
always_comb begin
	io_rd = `GBM_RD_UNDEF;
	unique case ({ea[11:1], 1'b0})
		`GBM_OFF_SP: io_rd = is_byte ? {sp_hi_r, 1'b0} : `GBM_RD_UNDEF;
		`GBM_OFF_RBS: io_rd = is_byte ? {mem_bank_select_r, 2'b00, reg_bank_select_r} :
			(ea[0] ? {4'h0, mem_bank_select_r} : {6'h00, reg_bank_select_r});
		`GBM_OFF_SBS: io_rd = ea[0] ? `GBM_RD_UNDEF : {4'h0, sbs_r};
		`GBM_OFF_BT: io_rd = is_byte ? bt_count_i : `GBM_RD_UNDEF;
		`GBM_OFF_DISPLAY_MODE: io_rd = is_byte ? display_mode_r : `GBM_RD_UNDEF;
		`GBM_OFF_DISPLAY_CONTROL: io_rd = ea[0] ? {4'h0, lps_r} : {4'h0, display_control_r};
		`GBM_OFF_TM2: io_rd = tm2_r;
		`GBM_OFF_T2C: io_rd = {4'h0, 1'b0, t2c_r[2:0]};
		`GBM_OFF_T2: io_rd = t2_count_i;
		`GBM_OFF_TIMER2_MODULO: io_rd = timer2_modulo_r;
		`GBM_OFF_WM: io_rd = wm_r;
		`GBM_OFF_TM0: io_rd = tm0_r;
		`GBM_OFF_T0: io_rd = t0_count_i;
		`GBM_OFF_TIMER0_MODULO: io_rd = timer0_modulo_r;
		`GBM_OFF_TM1: io_rd = tm1_r;
		`GBM_OFF_FLAGS: io_rd = {4'h0, 2'b00, mem_bank_enable_r, reg_bank_enable_r};
		default: io_rd = `GBM_RD_UNDEF;
	endcase
end

logic [7:0] gpr_rd;
logic [7:0] rd_bit;
assign gpr_rd = {gpr_r[{ea[4:1], 1'b1}], gpr_r[{ea[4:1], 1'b0}]};
// Odd address picks the high nibble of the pair
wire [3:0] gpr_nib = ea[0] ? gpr_rd[7:4] : gpr_rd[3:0];
always_comb begin
	rd_bit = 8'h00;
	if (is_bit) begin
		rd_bit = {7'h00, io_rd[{ea[0] & nib_sel, req_i.bitno}]};
	end
end

////////////////////////////////////////////////////////////////////////////
// General registers
// pairs low nibble at even offset
genvar gi;
generate
	for (gi = 0; gi < 32; gi = gi + 1) begin : g_gpr
		wire hit_lo = gpr_hit && req_i.wr && (ea[4:0] == 5'(gi));
		wire hit_hi = gpr_hit && req_i.wr && is_byte && ({ea[4:1], 1'b1} == 5'(gi));
		always_ff @(posedge clk_i) begin
			if (srst_i) begin
				gpr_r[gi] <= `GBM_RST_4;
			end else if (hit_hi) begin
				gpr_r[gi] <= wdat[7:4];
			end else if (hit_lo) begin
				gpr_r[gi] <= is_bit ? bit_merge(gpr_r[gi], req_i.bitno, bit_val) : wdat[3:0];
			end
		end
	end
endgenerate

////////////////////////////////////////////////////////////////////////////
// Bank flags
wire flags_bit_wr = wr_io && is_bit && (ea == `GBM_OFF_FLAGS);
wire rbe_irq_push = ctl_i.call | ctl_i.irq;
logic rbe_nxt;
always_comb begin
	rbe_nxt = reg_bank_enable_r;
	// bit set or clear on enable
	if (ctl_i.bit_set && !ctl_i.flag_mbe) begin
		rbe_nxt = 1'b1;
	end else if (ctl_i.bit_clr && !ctl_i.flag_mbe) begin
		rbe_nxt = 1'b0;
	end else if (flags_bit_wr && req_i.bitno == `GBM_BIT_RBE) begin
		rbe_nxt = bit_val;
	end
	if (ctl_i.irq) begin
		rbe_nxt = ctl_i.irq_rbe;
	end else if (ctl_i.ret) begin
		rbe_nxt = rbe_stack_r[0];
	end
end

always_ff @(posedge clk_i) begin
	if (srst_i) begin
		reg_bank_enable_r <= 1'b0;
		rbe_stack_r <= `GBM_RST_8;
	end else begin
		reg_bank_enable_r <= rbe_nxt;
		if (rbe_irq_push) begin
			rbe_stack_r <= {rbe_stack_r[6:0], reg_bank_enable_r};
		end else if (ctl_i.ret) begin
			rbe_stack_r <= {1'b0, rbe_stack_r[7:1]};
		end
	end
end

always_ff @(posedge clk_i) begin
	if (srst_i) begin
		mem_bank_enable_r <= 1'b0;
		reg_bank_select_r <= 2'b00;
		mem_bank_select_r <= `GBM_RST_4;
	end else begin
		if (ctl_i.bit_set && ctl_i.flag_mbe) begin
			mem_bank_enable_r <= 1'b1;
		end else if (ctl_i.bit_clr && ctl_i.flag_mbe) begin
			mem_bank_enable_r <= 1'b0;
		end else if (flags_bit_wr && req_i.bitno == `GBM_BIT_MBE) begin
			mem_bank_enable_r <= bit_val;
		end
		if (ctl_i.sel_rb) begin
			reg_bank_select_r <= ctl_i.sel_val[1:0];
		end
		if (ctl_i.sel_mb) begin
			mem_bank_select_r <= ctl_i.sel_val;
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// Peripheral registers
wire wa_byte = wr_io && is_byte;
wire wa_nib = wr_io && is_nib;
wire wa_bit = wr_io && is_bit;
// only bit 3 of the mode registers may be bit-written
wire bit3_ok = wa_bit && (req_i.bitno == `GBM_BIT_MODE);
always_ff @(posedge clk_i) begin
	if (srst_i) begin
		sp_hi_r <= 7'h00;
		sbs_r <= `GBM_RST_SBS;
		btm_r <= `GBM_RST_4;
		wdt_r <= 1'b0;
		display_mode_r <= `GBM_RST_8;
		display_control_r <= `GBM_RST_4;
		lps_r <= `GBM_RST_4;
		tm2_r <= `GBM_RST_8;
		t2c_r <= `GBM_RST_4;
		timer2_modulo_r <= `GBM_RST_8;
		wm_r <= `GBM_RST_8;
		tm0_r <= `GBM_RST_8;
		timer0_output_enable_r <= 1'b0;
		timer0_modulo_r <= `GBM_RST_8;
		tm1_r <= `GBM_RST_8;
	end else begin
		if (wa_byte && ea == `GBM_OFF_SP) begin
			sp_hi_r <= wdat[7:1];
		end
		if (wa_nib && ea == `GBM_OFF_SBS) begin
			sbs_r <= wdat[3:0];
		end
		if (wa_nib && ea == `GBM_OFF_BTM) begin
			btm_r <= wdat[3:0];
		end else if (bit3_ok && ea == `GBM_OFF_BTM) begin
			btm_r <= bit_merge(btm_r, `GBM_BIT_MODE, bit_val);
		end
		if (bit3_ok && ea == `GBM_OFF_WDT && bit_val) begin
			wdt_r <= 1'b1;
		end
		if (wa_byte && ea == `GBM_OFF_DISPLAY_MODE) begin
			display_mode_r <= wdat;
		end else if (bit3_ok && ea == `GBM_OFF_DISPLAY_MODE) begin
			display_mode_r[3] <= bit_val;
		end
		if (wa_nib && ea == `GBM_OFF_DISPLAY_CONTROL) begin
			display_control_r <= wdat[3:0];
		end
		if (wa_nib && ea == `GBM_OFF_LPS) begin
			lps_r <= wdat[3:0];
		end
		if (wa_byte && ea == `GBM_OFF_TM2) begin
			tm2_r <= wdat;
		end else if (bit3_ok && ea == `GBM_OFF_TM2) begin
			tm2_r[3] <= bit_val;
		end
		if ((wa_byte || wa_nib) && ea == `GBM_OFF_T2C) begin
			t2c_r <= wdat[3:0];
		end else if (wa_bit && ea == `GBM_OFF_T2C) begin
			t2c_r <= bit_merge(t2c_r, req_i.bitno, bit_val);
		end
		if (wa_byte && ea == `GBM_OFF_TIMER2_MODULO) begin
			timer2_modulo_r <= wdat;
		end
		if (wa_byte && ea == `GBM_OFF_WM) begin
			wm_r <= wdat;
		end
		if (wa_byte && ea == `GBM_OFF_TM0) begin
			tm0_r <= wdat;
		end else if (bit3_ok && ea == `GBM_OFF_TM0) begin
			tm0_r[3] <= bit_val;
		end
		if (wa_bit && ea == `GBM_OFF_TIMER0_OUTPUT_ENABLE) begin
			timer0_output_enable_r <= bit_val;
		end
		if (wa_byte && ea == `GBM_OFF_TIMER0_MODULO) begin
			timer0_modulo_r <= wdat;
		end
		if (wa_byte && ea == `GBM_OFF_TM1) begin
			tm1_r <= wdat;
		end else if (bit3_ok && ea == `GBM_OFF_TM1) begin
			tm1_r[3] <= bit_val;
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// Answer and pair outputs, all registered
// write-only spots answer a fixed value when read
wire [7:0] rd_mux = is_bit ? (io_ok ? rd_bit : {7'h00, gpr_nib[req_i.bitno]}) :
	io_ok ? io_rd : gpr_hit ? (is_byte ? gpr_rd : {4'h0, gpr_nib}) : `GBM_RD_UNDEF;
always_ff @(posedge clk_i) begin
	if (srst_i) begin
		rsp_r <= '0;
	end else begin
		rsp_r.valid <= req_i.valid && !req_i.wr;
		rsp_r.rdata <= rd_mux;
		rsp_r.gpr <= gpr_hit;
		rsp_r.io <= io_ok;
		rsp_r.disp <= disp_hit;
		rsp_r.eff_addr <= ea;
	end
end
assign rsp_o = rsp_r;

logic [7:0] xa_r;
logic [7:0] hl_r;
logic [7:0] de_r;
logic [7:0] dl_r;
logic [7:0] bc_r;
logic [7:0] xa_alt_r;
always_ff @(posedge clk_i) begin
	if (srst_i) begin
		xa_r <= `GBM_RST_8;
		hl_r <= `GBM_RST_8;
		de_r <= `GBM_RST_8;
		dl_r <= `GBM_RST_8;
		bc_r <= `GBM_RST_8;
		xa_alt_r <= `GBM_RST_8;
	end else begin
		xa_r <= {gpr_r[gpr_idx(rb, 3'd1)], gpr_r[gpr_idx(rb, 3'd0)]};
		hl_r <= {gpr_r[gpr_idx(rb, 3'd3)], gpr_r[gpr_idx(rb, 3'd2)]};
		de_r <= {gpr_r[gpr_idx(rb, 3'd5)], gpr_r[gpr_idx(rb, 3'd4)]};
		dl_r <= {gpr_r[gpr_idx(rb, 3'd5)], gpr_r[gpr_idx(rb, 3'd2)]};
		bc_r <= {gpr_r[gpr_idx(rb, 3'd7)], gpr_r[gpr_idx(rb, 3'd6)]};
		xa_alt_r <= {gpr_r[gpr_idx(rb_alt, 3'd1)], gpr_r[gpr_idx(rb_alt, 3'd0)]};
	end
end

logic [1:0] rb_r;
always_ff @(posedge clk_i) begin
	if (srst_i) begin
		rb_r <= 2'b00;
	end else begin
		rb_r <= rb;
	end
end

assign active_reg_bank_o = rb_r;
assign reg_bank_enable_o = reg_bank_enable_r;
assign mem_bank_enable_o = mem_bank_enable_r;
assign mem_bank_select_o = mem_bank_select_r;
assign acc_pair_o = xa_r;
assign main_pointer_pair_o = hl_r;
assign aux_pointer_pair_o = de_r;
assign aux_pointer_pair_b_o = dl_r;
assign general_pair_b_o = bc_r;
assign acc_pair_alt_o = xa_alt_r;
assign stack_pointer_o = {sp_hi_r, 1'b0};
assign stack_bank_selection_o = sbs_r;
assign watchdog_enable_flag_o = wdt_r;
assign timer0_output_enable_o = timer0_output_enable_r;
assign ctl_regs_o = {tm1_r, tm0_r, btm_r, t2c_r, display_mode_r};

endmodule
`default_nettype wire

/* File: hdl/gbm_consts.svh */
/*
 Register bank and I/O map constants: offsets, field positions, reset values.
 Assumes inclusion by the design file only.
*/
`ifndef GBM_CONSTS_SVH
`define GBM_CONSTS_SVH
`define GBM_GPR_LAST 12'h01F
`define GBM_DISP_FIRST 12'h1E0
`define GBM_DISP_LAST 12'h1F7
`define GBM_IO_FIRST 12'hF80
`define GBM_FMEM_INT_FIRST 12'hFB0
`define GBM_FMEM_INT_LAST 12'hFBF
`define GBM_FMEM_PORT_FIRST 12'hFF0
`define GBM_FMEM_PORT_LAST 12'hFF9
`define GBM_MBS_IO 4'hF
`define GBM_MBS_DISP 4'h1
`define GBM_MBS_GPR 4'h0
`define GBM_OFF_SP 12'hF80
`define GBM_OFF_RBS 12'hF82
`define GBM_OFF_MBS 12'hF83
`define GBM_OFF_SBS 12'hF84
`define GBM_OFF_BTM 12'hF85
`define GBM_OFF_BT 12'hF86
`define GBM_OFF_WDT 12'hF8B
`define GBM_OFF_DISPLAY_MODE 12'hF8C
`define GBM_OFF_DISPLAY_CONTROL 12'hF8E
`define GBM_OFF_LPS 12'hF8F
`define GBM_OFF_TM2 12'hF90
`define GBM_OFF_T2C 12'hF92
`define GBM_OFF_T2 12'hF94
`define GBM_OFF_TIMER2_MODULO 12'hF96
`define GBM_OFF_WM 12'hF98
`define GBM_OFF_TM0 12'hFA0
`define GBM_OFF_TIMER0_OUTPUT_ENABLE 12'hFA2
`define GBM_OFF_T0 12'hFA4
`define GBM_OFF_TIMER0_MODULO 12'hFA6
`define GBM_OFF_TM1 12'hFA8
`define GBM_OFF_FLAGS 12'hFB0
`define GBM_BIT_RBE 2'h0
`define GBM_BIT_MBE 2'h1
`define GBM_BIT_MODE 2'h3
`define GBM_BIT_T2_WO 2'h3
`define GBM_RST_SBS 4'h8
`define GBM_RST_4 4'h0
`define GBM_RST_8 8'h00
`define GBM_RD_UNDEF 8'h00
`endif

/* File: hdl/gbm_pkg.sv */
/*
 Types for the register bank and I/O map block.
 Assumes gbm_consts.svh is on the include path.
*/
package gbm_pkg;
	typedef enum logic [2:0] {
		GBM_BIT = 3'b001,
		GBM_NIB = 3'b010,
		GBM_BYTE = 3'b100
	} gbm_width_t;
	typedef enum logic [3:0] {
		GBM_DIRECT = 4'b0001,
		GBM_FMEM = 4'b0010,
		GBM_IND_HL = 4'b0100,
		GBM_IND_DE = 4'b1000
	} gbm_mode_t;
	typedef struct packed {
		logic valid;
		logic wr;
		gbm_width_t width;
		gbm_mode_t mode;
		logic [11:0] addr;
		logic [1:0] bitno;
		logic [7:0] wdata;
	} gbm_req_t;
	typedef struct packed {
		logic valid;
		logic [7:0] rdata;
		logic gpr;
		logic io;
		logic disp;
		logic [11:0] eff_addr;
	} gbm_rsp_t;
	typedef struct packed {
		logic call;
		logic irq;
		logic irq_rbe;
		logic ret;
		logic bit_set;
		logic bit_clr;
		logic flag_mbe;
		logic sel_rb;
		logic sel_mb;
		logic [3:0] sel_val;
	} gbm_ctl_t;
endpackage

/* File: dv/gbm_regmap_sva.sv */
/*
 Port checker for the register bank and I/O map block.
 Assumes one clock, a synchronous active-high reset and the package types.
*/
`timescale 1ns/10ps
`default_nettype none
module gbm_regmap_sva (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire gbm_pkg::gbm_req_t req_i,
	input wire gbm_pkg::gbm_ctl_t ctl_i,
	input wire logic [7:0] bt_count_i,
	input wire gbm_pkg::gbm_rsp_t rsp_o,
	input wire logic [1:0] active_reg_bank_o,
	input wire logic reg_bank_enable_o,
	input wire logic mem_bank_enable_o,
	input wire logic [3:0] mem_bank_select_o,
	input wire logic [7:0] stack_pointer_o,
	input wire logic watchdog_enable_flag_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	////////////////////////////////////////////////////////////////////////
	wire logic rd_q = req_i.valid && !req_i.wr;
	wire logic rd_dir = rd_q && req_i.mode == gbm_pkg::GBM_DIRECT;
	wire logic hi_addr = req_i.addr >= 12'hF80;
	wire logic io_open = !mem_bank_enable_o || mem_bank_select_o == 4'hF;
	////////////////////////////////////////////////////////////////////////
	a_sp_even: assert property (stack_pointer_o[0] == 1'b0)
		else $error("stack pointer bit 0 set");
	a_bank_gate: assert property (!reg_bank_enable_o |=> active_reg_bank_o == 2'h0)
		else $error("bank not 0 with enable clear");
	a_wdt_sticky: assert property (watchdog_enable_flag_o |=> watchdog_enable_flag_o)
		else $error("watchdog flag cleared");
	a_irq_loads: assert property (ctl_i.irq |=> reg_bank_enable_o == $past(ctl_i.irq_rbe))
		else $error("interrupt entry did not load enable");
	a_bt_read: assert property (rd_dir && req_i.addr == 12'hF86 && !mem_bank_enable_o
		|=> rsp_o.valid && rsp_o.io && rsp_o.rdata == $past(bt_count_i))
		else $error("interval count read wrong");
	a_io_open: assert property (rd_dir && hi_addr && io_open |=> rsp_o.io)
		else $error("peripheral not decoded");
	a_io_gated: assert property (rd_dir && hi_addr && !io_open |=> !rsp_o.io)
		else $error("peripheral reached with wrong bank");
	a_hl_io: assert property (rd_q && req_i.mode == gbm_pkg::GBM_IND_HL && hi_addr
		&& mem_bank_enable_o && mem_bank_select_o == 4'hF |=> rsp_o.io)
		else $error("indirect peripheral access missed");
	a_disp_map: assert property (rd_dir && mem_bank_enable_o && mem_bank_select_o == 4'h1
		&& req_i.addr >= 12'h1E0 && req_i.addr <= 12'h1F7 |=> rsp_o.disp)
		else $error("display memory not flagged");
	a_wo_read: assert property (rd_dir && req_i.addr == 12'hF8B && io_open
		|=> rsp_o.rdata == 8'h00)
		else $error("write-only read not zero");
	c_hl_io: cover property (rd_q && req_i.mode == gbm_pkg::GBM_IND_HL && mem_bank_select_o == 4'hF);
	c_wdt_on: cover property ($rose(watchdog_enable_flag_o));
	c_irq: cover property (ctl_i.irq ##[1:20] ctl_i.ret);
endmodule
bind gbm_regmap gbm_regmap_sva i_sva (
	.clk_i(clk_i),
	.srst_i(srst_i),
	.req_i(req_i),
	.ctl_i(ctl_i),
	.bt_count_i(bt_count_i),
	.rsp_o(rsp_o),
	.active_reg_bank_o(active_reg_bank_o),
	.reg_bank_enable_o(reg_bank_enable_o),
	.mem_bank_enable_o(mem_bank_enable_o),
	.mem_bank_select_o(mem_bank_select_o),
	.stack_pointer_o(stack_pointer_o),
	.watchdog_enable_flag_o(watchdog_enable_flag_o)
);
`default_nettype wire

/* File: dv/gbm_cpu_model.sv */
/*
 Execution unit model: issues one memory access or control pulse at a time.
 Assumes the block answers a read in the cycle after it is taken.
*/
`timescale 1ns/10ps
`default_nettype none
module gbm_cpu_model (
	input wire logic clk_i,
	input wire gbm_pkg::gbm_rsp_t rsp_i,
	output var gbm_pkg::gbm_req_t req_o,
	output var gbm_pkg::gbm_ctl_t ctl_o
);
	initial begin
		req_o = '0;
		ctl_o = '0;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic acc(input logic wr, input gbm_pkg::gbm_width_t w,
		input gbm_pkg::gbm_mode_t m, input logic [11:0] a, input logic [1:0] b,
		input logic [7:0] d, output gbm_pkg::gbm_rsp_t r);
		gbm_pkg::gbm_req_t q;
		q = '{valid: 1'b1, wr: wr, width: w, mode: m, addr: a, bitno: b, wdata: d};
		if (w == gbm_pkg::GBM_BYTE) q.addr[0] = 1'b0;
		@(posedge clk_i);
		req_o <= q;
		@(posedge clk_i);
		req_o <= '0;
		#1 r = rsp_i;
	endtask
	// Extra edge lets the one-cycle-late bank output settle before checks
	task automatic pulse(input gbm_pkg::gbm_ctl_t c);
		@(posedge clk_i);
		ctl_o <= c;
		@(posedge clk_i);
		ctl_o <= '0;
		@(posedge clk_i);
		#1;
	endtask
endmodule
`default_nettype wire

/* File: dv/gbm_regmap_tb.sv */
/*
 Self-checking bench for the register bank and I/O map block.
 Assumes the checker is bound to the design and the execution unit model.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module gbm_regmap_tb;
	localparam gbm_pkg::gbm_width_t w_bit = gbm_pkg::GBM_BIT;
	localparam gbm_pkg::gbm_width_t w_nib = gbm_pkg::GBM_NIB;
	localparam gbm_pkg::gbm_width_t w_byte = gbm_pkg::GBM_BYTE;
	localparam gbm_pkg::gbm_mode_t m_dir = gbm_pkg::GBM_DIRECT;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [7:0] cnt [3] = '{8'h3C, 8'h5A, 8'hC3};
	logic [11:0] cnt_addr [3] = '{12'hF86, 12'hF94, 12'hFA4};
	logic [11:0] mode_addr [4] = '{12'hF8C, 12'hF85, 12'hFA0, 12'hFA8};
	int mode_pos [4] = '{3, 15, 19, 27};
	gbm_pkg::gbm_req_t req;
	gbm_pkg::gbm_ctl_t ctl;
	gbm_pkg::gbm_rsp_t rsp_w, rsp;
	logic [1:0] rb;
	logic reg_bank_enable, mem_bank_enable, wdt, timer0_output_enable;
	logic [3:0] mem_bank_select, stack_bank_selection;
	logic [7:0] xa, hl, de, dl, bc, xa2, sp;
	logic [31:0] cregs, cexp;
	logic [3:0] gpr [32];
	int n_errors = 0;
	int check_count = 0;
	always #2.5 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////////////
	gbm_cpu_model i_cpu (.clk_i(clk_i), .rsp_i(rsp_w), .req_o(req), .ctl_o(ctl));
	gbm_regmap i_dut (
		.clk_i(clk_i), .srst_i(srst_i), .req_i(req), .ctl_i(ctl),
		.bt_count_i(cnt[0]), .t2_count_i(cnt[1]), .t0_count_i(cnt[2]), .rsp_o(rsp_w),
		.active_reg_bank_o(rb), .reg_bank_enable_o(reg_bank_enable), .mem_bank_enable_o(mem_bank_enable),
		.mem_bank_select_o(mem_bank_select), .acc_pair_o(xa), .main_pointer_pair_o(hl),
		.aux_pointer_pair_o(de), .aux_pointer_pair_b_o(dl), .general_pair_b_o(bc),
		.acc_pair_alt_o(xa2), .stack_pointer_o(sp), .stack_bank_selection_o(stack_bank_selection),
		.watchdog_enable_flag_o(wdt), .timer0_output_enable_o(timer0_output_enable), .ctl_regs_o(cregs)
	);
	////////////////////////////////////////////////////////////////////////
	task automatic rd(input gbm_pkg::gbm_width_t w, input gbm_pkg::gbm_mode_t m,
		input logic [11:0] a);
		i_cpu.acc(1'b0, w, m, a, 2'h0, 8'h00, rsp);
	endtask
	task automatic wr(input gbm_pkg::gbm_width_t w, input gbm_pkg::gbm_mode_t m,
		input logic [11:0] a, input logic [1:0] b, input logic [7:0] d);
		i_cpu.acc(1'b1, w, m, a, b, d, rsp);
	endtask
	task automatic chk_pairs(input int b);
		int o;
		int p;
		o = 8 * b;
		p = 8 * (b ^ 1);
		`CHK("xa", {gpr[o+1], gpr[o]}, xa)
		`CHK("hl", {gpr[o+3], gpr[o+2]}, hl)
		`CHK("de", {gpr[o+5], gpr[o+4]}, de)
		`CHK("dl", {gpr[o+5], gpr[o+2]}, dl)
		`CHK("bc", {gpr[o+7], gpr[o+6]}, bc)
		`CHK("xa alt", {gpr[p+1], gpr[p]}, xa2)
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Guard against a hang anywhere in the sequence
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		test_done();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk_i);
		srst_i <= 1'b0;
		#1;
		`CHK("sbs reset", 4'h8, stack_bank_selection)
		`CHK("rbe reset", 1'b0, reg_bank_enable)
		for (int a = 0; a < 32; a++) begin
			gpr[a] = 4'(a * 5 + 3);
			wr(w_nib, m_dir, 12'(a), 2'h0, {4'h0, gpr[a]});
		end
		i_cpu.pulse('{default: '0, bit_set: 1'b1});
		for (int b = 0; b < 4; b++) begin
			i_cpu.pulse('{default: '0, sel_rb: 1'b1, sel_val: 4'(b)});
			`CHK("bank", 2'(b), rb)
			chk_pairs(b);
		end
		i_cpu.pulse('{default: '0, sel_rb: 1'b1, sel_val: 4'h7});
		rd(w_nib, m_dir, 12'hF82);
		`CHK("rbs fixed", 8'h03, rsp.rdata)
		i_cpu.pulse('{default: '0, bit_clr: 1'b1});
		`CHK("bank off", 2'h0, rb)
		i_cpu.pulse('{default: '0, bit_set: 1'b1});
		i_cpu.pulse('{default: '0, call: 1'b1});
		i_cpu.pulse('{default: '0, bit_clr: 1'b1});
		`CHK("rbe in sub", 1'b0, reg_bank_enable)
		i_cpu.pulse('{default: '0, ret: 1'b1});
		`CHK("rbe ret", 1'b1, reg_bank_enable)
		i_cpu.pulse('{default: '0, irq: 1'b1, irq_rbe: 1'b0});
		`CHK("rbe irq", 1'b0, reg_bank_enable)
		i_cpu.pulse('{default: '0, ret: 1'b1});
		`CHK("rbe reti", 1'b1, reg_bank_enable)
		i_cpu.pulse('{default: '0, sel_mb: 1'b1, sel_val: 4'h5});
		wr(w_byte, m_dir, 12'hF82, 2'h0, 8'hFF);
		rd(w_byte, m_dir, 12'hF82);
		`CHK("bank sel", 8'h53, rsp.rdata)
		wr(w_byte, m_dir, 12'hF80, 2'h0, 8'hA7);
		wr(w_nib, m_dir, 12'hF80, 2'h0, 8'h05);
		rd(w_byte, m_dir, 12'hF80);
		`CHK("sp", 8'hA6, rsp.rdata)
		for (int i = 0; i < 3; i++) begin
			rd(w_byte, m_dir, cnt_addr[i]);
			`CHK("count", cnt[i], rsp.rdata)
		end
		wr(w_bit, m_dir, 12'hF8B, 2'h0, 8'hFF);
		`CHK("wdt bit0", 1'b0, wdt)
		wr(w_bit, m_dir, 12'hF8B, 2'h3, 8'hFF);
		wr(w_bit, m_dir, 12'hF8B, 2'h3, 8'h00);
		`CHK("wdt", 1'b1, wdt)
		rd(w_nib, m_dir, 12'hF8B);
		`CHK("wdt rd", 8'h00, rsp.rdata)
		cexp = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			wr(w_bit, m_dir, mode_addr[i], 2'h1, 8'hFF);
			wr(w_bit, m_dir, mode_addr[i], 2'h3, 8'hFF);
			cexp[mode_pos[i]] = 1'b1;
			`CHK("mode bit", cexp, cregs)
		end
		wr(w_nib, m_dir, 12'hF92, 2'h0, 8'h0F);
		cexp[11:8] = 4'hF;
		`CHK("t2 ctl", cexp, cregs)
		rd(w_nib, m_dir, 12'hF92);
		`CHK("t2 ctl rd", 8'h07, rsp.rdata)
		wr(w_bit, m_dir, 12'hFA2, 2'h3, 8'hFF);
		`CHK("timer0_output_enable set", 1'b1, timer0_output_enable)
		wr(w_bit, m_dir, 12'hFA2, 2'h3, 8'h00);
		`CHK("timer0_output_enable clr", 1'b0, timer0_output_enable)
		i_cpu.pulse('{default: '0, bit_set: 1'b1, flag_mbe: 1'b1});
		i_cpu.pulse('{default: '0, sel_mb: 1'b1, sel_val: 4'h0});
		rd(w_byte, m_dir, 12'hF86);
		`CHK("gated", 1'b0, rsp.io)
		i_cpu.pulse('{default: '0, sel_mb: 1'b1, sel_val: 4'hF});
		rd(w_byte, m_dir, 12'hF86);
		`CHK("open", 9'h13C, {rsp.io, rsp.rdata})
		rd(w_byte, gbm_pkg::GBM_IND_HL, 12'hF86);
		`CHK("hl io", 1'b1, rsp.io)
		i_cpu.pulse('{default: '0, sel_mb: 1'b1, sel_val: 4'h1});
		rd(w_byte, gbm_pkg::GBM_IND_HL, 12'hF86);
		`CHK("hl gated", 1'b0, rsp.io)
		rd(w_nib, m_dir, 12'h1F7);
		`CHK("disp in", 1'b1, rsp.disp)
		rd(w_nib, m_dir, 12'h1F8);
		`CHK("disp out", 1'b0, rsp.disp)
		wr(w_bit, gbm_pkg::GBM_FMEM, 12'hFB0, 2'h0, 8'h00);
		`CHK("fmem rbe", 1'b0, reg_bank_enable)
		wr(w_bit, gbm_pkg::GBM_FMEM, 12'hFB0, 2'h1, 8'h00);
		`CHK("fmem mbe", 1'b0, mem_bank_enable)
		rd(w_nib, m_dir, 12'hFFF);
		`CHK("io top", 1'b1, rsp.io)
		rd(w_nib, m_dir, 12'hF7F);
		`CHK("io below", 1'b0, rsp.io)
		rd(w_nib, m_dir, 12'h003);
		`CHK("gpr rd", {2'b11, 12'h003, 4'h0, gpr[3]}, {rsp.valid, rsp.gpr, rsp.eff_addr, rsp.rdata})
		test_done();
	end
endmodule
`default_nettype wire
